// *** sfpc_host.sv ***
`timescale 1ns/10ps
// How it works
// - Each load pulses write strobe low under chip enable, output enable high.
// - Next load falls within the window, else programming starts.
// - Sector address stays fixed per load; byte offsets in any order.
// - End of cycle is found by polling the top data bit and bit six.
// - Three fixed commands enable the guard and open every guarded program.
// - Guard command bytes use ordinary load timing and window.
module sfpc_host #(
   parameter logic [20:0] LOAD_WINDOW_CYC = sfpc_pkg::LOAD_WINDOW_CYC,
   parameter logic [20:0] PROG_CYCLE_CYC  = sfpc_pkg::PROG_CYCLE_CYC
) (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic                   cmd_valid,
   output logic                        cmd_ready,
   input  wire sfpc_pkg::sfpc_cmd_t    cmd,
   input  wire logic                   wr_valid,
   output logic                        wr_ready,
   input  wire sfpc_pkg::sfpc_load_t   wr_load,
   output logic                        rsp_valid,
   output sfpc_pkg::sfpc_rsp_t         rsp,
   output logic                        guard_active,
   output sfpc_pkg::sfpc_pins_t        pins,
   input  wire logic [7:0]             dq_in
);
   // ==========================================================================
   // State
   // ==========================================================================
   typedef enum logic [3:0] {
      S_IDLE, S_SEQ, S_FETCH, S_WSET, S_WLOW, S_WHIGH, S_SETTLE, S_PREAD, S_PGAP
   } sfpc_state_t;

   typedef struct packed {
      sfpc_state_t                    st;
      sfpc_pkg::sfpc_op_t             op;
      logic                           in_seq;
      logic [1:0]                     idx;
      logic [sfpc_pkg::COUNT_W-1:0]   remain;
      logic [sfpc_pkg::SECT_W-1:0]    sector;
      logic [sfpc_pkg::TW-1:0]        cnt;
      logic [sfpc_pkg::TW-1:0]        gap;
      logic [sfpc_pkg::TW-1:0]        total;
      logic                           loaded;
      logic [sfpc_pkg::ADDR_W-1:0]    addr;
      logic [sfpc_pkg::DATA_W-1:0]    data;
      logic                           seen;
      logic                           prev_b6;
      logic                           guard;
      logic                           rsp_valid;
      sfpc_pkg::sfpc_rsp_t            rsp;
      sfpc_pkg::sfpc_pins_t           pins;
   } sfpc_host_state_t;

   sfpc_host_state_t     q;
   sfpc_host_state_t     next_q;
   sfpc_pkg::sfpc_load_t fifo_data;
   logic                 fifo_valid;
   logic                 fifo_pop;
   logic                 poll_done;

   // ==========================================================================
   // Load buffer
   // ==========================================================================
   // The buffer lets software run ahead of the strobes; an empty buffer in the
   // middle of a sector is still limited by the load window below.
   sfpc_fifo #(
      .WIDTH ($bits(sfpc_pkg::sfpc_load_t)),
      .DEPTH (sfpc_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (wr_valid),
      .in_ready  (wr_ready),
      .in_data   (wr_load),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );

   assign fifo_pop     = (q.st == S_FETCH) && fifo_valid;
   assign cmd_ready    = (q.st == S_IDLE);
   assign rsp_valid    = q.rsp_valid;
   assign rsp          = q.rsp;
   assign guard_active = q.guard;
   assign pins         = q.pins;

   // Done needs the top bit equal to the written data's top bit and bit six steady over two reads.
   assign poll_done = q.seen && (dq_in[7] == q.data[7]) && (dq_in[6] == q.prev_b6);

   // ==========================================================================
   // Sequencer
   // ==========================================================================
   always_comb begin
      next_q           = q;
      next_q.rsp_valid = 1'b0;
      next_q.gap       = (&q.gap) ? q.gap : q.gap + 21'h00001;
      next_q.total     = (q.st == S_IDLE || q.st == S_SETTLE) ? '0 :
                         ((&q.total) ? q.total : q.total + 21'h00001);
      case (q.st)
         S_IDLE: begin
            if (cmd_valid) begin
               next_q.op       = cmd.op;
               next_q.sector   = cmd.addr[sfpc_pkg::ADDR_W-1:sfpc_pkg::OFS_W];
               next_q.addr     = cmd.addr;
               next_q.remain   = (cmd.count == '0) ? 9'h001 : cmd.count;
               next_q.idx      = 2'h0;
               next_q.loaded   = 1'b0;
               next_q.seen     = 1'b0;
               next_q.rsp      = '0;
               next_q.in_seq   = 1'b0;
               if (cmd.op == sfpc_pkg::OP_READ) begin
                  next_q.st = S_PREAD;
               end else if (cmd.op == sfpc_pkg::OP_PROGRAM && !q.guard) begin
                  next_q.st = S_FETCH;
               end else begin
                  next_q.in_seq = 1'b1;
                  next_q.st     = S_SEQ;
               end
            end
         end
         S_SEQ: begin
            if (q.op == sfpc_pkg::OP_GUARD_OFF) begin
               next_q.addr = sfpc_pkg::GUARD_OFF_ADDR[q.idx];
               next_q.data = sfpc_pkg::GUARD_OFF_DATA[q.idx];
            end else begin
               next_q.addr = sfpc_pkg::GUARD_ON_ADDR[q.idx];
               next_q.data = sfpc_pkg::GUARD_ON_DATA[q.idx];
            end
            next_q.st = S_WSET;
         end
         S_FETCH: begin
            if (fifo_valid) begin
               next_q.addr   = {q.sector, fifo_data.offset};
               next_q.data   = fifo_data.data;
               next_q.remain = q.remain - 9'h001;
               next_q.st     = S_WSET;
            end else if (q.loaded && q.gap >= LOAD_WINDOW_CYC - sfpc_pkg::GAP_MARGIN) begin
               // Too late for another load: the sector goes as loaded so far.
               next_q.rsp.err_underrun = 1'b1;
               next_q.st               = S_SETTLE;
            end
         end
         S_WSET: begin
            next_q.st = S_WLOW;
         end
         S_WLOW: begin
            if (q.cnt == sfpc_pkg::WE_LOW_CYC - 21'h00001) begin
               next_q.st     = S_WHIGH;
               next_q.gap    = '0;
               next_q.loaded = 1'b1;
            end
         end
         S_WHIGH: begin
            if (q.cnt == sfpc_pkg::WE_HIGH_CYC - 21'h00001) begin
               if (q.in_seq) begin
                  if (q.idx == sfpc_pkg::SEQ_LAST) begin
                     next_q.in_seq = 1'b0;
                     next_q.st     = (q.op == sfpc_pkg::OP_PROGRAM) ? S_FETCH : S_SETTLE;
                  end else begin
                     next_q.idx = q.idx + 2'h1;
                     next_q.st  = S_SEQ;
                  end
               end else begin
                  next_q.st = (q.remain == '0) ? S_SETTLE : S_FETCH;
               end
            end
         end
         S_SETTLE: begin
            // Polling waits out the window so a read never lands in a load.
            if (q.gap > LOAD_WINDOW_CYC) begin
               next_q.st = S_PREAD;
            end
         end
         S_PREAD: begin
            if (q.cnt == sfpc_pkg::RD_WAIT_CYC - 21'h00001) begin
               next_q.rsp.data = dq_in;
               if (q.op == sfpc_pkg::OP_READ || poll_done) begin
                  next_q.rsp_valid = 1'b1;
                  next_q.st        = S_IDLE;
                  if (q.op == sfpc_pkg::OP_GUARD_ON) begin
                     next_q.guard = 1'b1;
                  end else if (q.op == sfpc_pkg::OP_GUARD_OFF) begin
                     next_q.guard = 1'b0;
                  end
               end else if (q.total >= PROG_CYCLE_CYC) begin
                  next_q.rsp.err_timeout = 1'b1;
                  next_q.rsp_valid       = 1'b1;
                  next_q.st              = S_IDLE;
               end else begin
                  next_q.prev_b6 = dq_in[6];
                  next_q.seen    = 1'b1;
                  next_q.st      = S_PGAP;
               end
            end
         end
         S_PGAP: begin
            if (q.cnt == sfpc_pkg::POLL_GAP_CYC - 21'h00001) begin
               next_q.st = S_PREAD;
            end
         end
         default: begin
            next_q.st = S_IDLE;
         end
      endcase

      next_q.cnt = (next_q.st != q.st) ? '0 : q.cnt + 21'h00001;

      // Pins follow the next state so every strobe comes from a flip-flop.
      next_q.pins.addr   = next_q.addr;
      next_q.pins.dq_out = next_q.data;
      next_q.pins.ce_n   = 1'b1;
      next_q.pins.oe_n   = 1'b1;
      next_q.pins.we_n   = 1'b1;
      next_q.pins.dq_oe  = 1'b0;
      case (next_q.st)
         S_SEQ, S_FETCH: begin
            next_q.pins.ce_n = 1'b0;
         end
         S_WSET, S_WHIGH: begin
            next_q.pins.ce_n  = 1'b0;
            next_q.pins.dq_oe = 1'b1;
         end
         S_WLOW: begin
            next_q.pins.ce_n  = 1'b0;
            next_q.pins.we_n  = 1'b0;
            next_q.pins.dq_oe = 1'b1;
         end
         S_PREAD: begin
            next_q.pins.ce_n = 1'b0;
            next_q.pins.oe_n = 1'b0;
         end
         default: begin
            next_q.pins.ce_n = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q           <= '0;
         q.st        <= S_IDLE;
         q.pins.ce_n <= 1'b1;
         q.pins.oe_n <= 1'b1;
         q.pins.we_n <= 1'b1;
      end else begin
         q <= next_q;
      end
   end
endmodule

// *** sfpc_pkg.sv ***
package sfpc_pkg;
   // ==========================================================================
   // Widths
   // ==========================================================================
   localparam int ADDR_W     = 19;
   localparam int DATA_W     = 8;
   localparam int OFS_W      = 8;
   localparam int SECT_W     = 11;
   localparam int COUNT_W    = 9;
   localparam int TW         = 21;
   localparam int FIFO_DEPTH = 16;

   // ==========================================================================
   // Timing
   // ==========================================================================
   localparam int CLK_PERIOD_NS   = 10;
   localparam int LOAD_WINDOW_US  = 150;
   localparam int PROG_CYCLE_MS   = 10;
   localparam int NOISE_FILTER_NS = 15;
   localparam logic [TW-1:0] LOAD_WINDOW_CYC =
      TW'((LOAD_WINDOW_US * 1000) / CLK_PERIOD_NS);
   localparam logic [TW-1:0] PROG_CYCLE_CYC =
      TW'((PROG_CYCLE_MS * 1000000) / CLK_PERIOD_NS);
   // One cycle beyond the filter so a load pulse is never taken for noise.
   localparam logic [TW-1:0] WE_LOW_CYC  =
      TW'((NOISE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1);
   localparam logic [TW-1:0] WE_HIGH_CYC  = WE_LOW_CYC;
   localparam logic [TW-1:0] RD_WAIT_CYC  = 21'h0000c;
   localparam logic [TW-1:0] POLL_GAP_CYC = 21'h00002;
   localparam logic [TW-1:0] GAP_MARGIN   = 21'h00010;
   localparam logic [1:0]    SEQ_LAST     = 2'h2;

   // ==========================================================================
   // Write guard command tables, entry 0 issued first
   // ==========================================================================
   localparam logic [2:0][ADDR_W-1:0] GUARD_ON_ADDR  = {19'h00333, 19'h00222, 19'h00111};
   localparam logic [2:0][DATA_W-1:0] GUARD_ON_DATA  = {8'h33, 8'h22, 8'h11};
   localparam logic [2:0][ADDR_W-1:0] GUARD_OFF_ADDR = {19'h00666, 19'h00555, 19'h00444};
   localparam logic [2:0][DATA_W-1:0] GUARD_OFF_DATA = {8'h66, 8'h55, 8'h44};

   // ==========================================================================
   // Carriers
   // ==========================================================================
   typedef enum logic [1:0] {OP_READ, OP_PROGRAM, OP_GUARD_ON, OP_GUARD_OFF} sfpc_op_t;

   typedef struct packed {
      sfpc_op_t            op;
      logic [ADDR_W-1:0]   addr;
      logic [COUNT_W-1:0]  count;
   } sfpc_cmd_t;

   typedef struct packed {
      logic [OFS_W-1:0]  offset;
      logic [DATA_W-1:0] data;
   } sfpc_load_t;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic              err_underrun;
      logic              err_timeout;
   } sfpc_rsp_t;

   typedef struct packed {
      logic              ce_n;
      logic              oe_n;
      logic              we_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_out;
      logic              dq_oe;
   } sfpc_pins_t;
endpackage

// *** sfpc_fifo.sv ***
`timescale 1ns/10ps
module sfpc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } sfpc_fifo_state_t;

   sfpc_fifo_state_t q;
   sfpc_fifo_state_t next_q;
   logic             push;
   logic             pop;

   assign in_ready  = q.cnt != (AW+1)'(DEPTH);
   assign out_valid = q.cnt != '0;
   assign out_data  = q.mem[q.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      next_q = q;
      if (push) begin
         next_q.mem[q.wp] = in_data;
         next_q.wp        = q.wp + AW'(1);
      end
      if (pop) begin
         next_q.rp = q.rp + AW'(1);
      end
      next_q.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end
endmodule

// *** sfpc_flash_model.sv ***
`timescale 1ns/10ps
// ============================================================
// Flash device seen from its pins
// ============================================================
module sfpc_flash_model #(
   parameter int LW = 200
) (
   input  wire logic                 clk,
   input  wire sfpc_pkg::sfpc_pins_t pins,
   output logic [7:0]                dq_in
);
   logic [7:0]  mem [int];
   logic [26:0] q [$];
   logic [18:0] la = 19'h00000;
   logic [7:0]  ld = 8'h00;
   logic        guard = 1'b0, pw = 1'b1, prd = 1'b0, tog = 1'b0, act = 1'b0;
   logic        lp = 1'b0, rd, on, off;
   int          win = 0, busy = 0, prog_t = 60, pon = 0, i;
   initial dq_in = 8'h00;
   function automatic logic [26:0] gw(input int k, input logic o);
      return o ? {sfpc_pkg::GUARD_OFF_ADDR[k], sfpc_pkg::GUARD_OFF_DATA[k]} :
                 {sfpc_pkg::GUARD_ON_ADDR[k], sfpc_pkg::GUARD_ON_DATA[k]};
   endfunction
   // A released bus shows the inverse of its last value, so a late sample is caught.
   always @(posedge clk) begin
      rd = !pins.ce_n && !pins.oe_n;
      if (busy > 0) busy--;
      // Loads are refused until the supply has been good for a short while.
      if (pon < 16) pon++;
      if (pw && !pins.we_n && !pins.ce_n && pins.oe_n && busy == 0 && pon >= 16) begin
         la  = pins.addr;
         act = 1'b1;
         lp  = 1'b0;
      end else if (!pw && pins.we_n && act) begin
         act = 1'b0;
         ld  = pins.dq_out;
         q.push_back({la, ld});
         win = 0;
         lp  = 1'b1;
      end else if (lp && ++win >= LW) begin
         lp   = 1'b0;
         busy = prog_t;
         on   = q.size() >= 3;
         off  = on;
         for (i = 0; i < 3 && i < q.size(); i++) begin
            on  = on && q[i] == gw(i, 1'b0);
            off = off && q[i] == gw(i, 1'b1);
         end
         if (on || off) begin
            guard = on;
            repeat (3) begin
               mem[q[0][26:8]] = q[0][7:0];
               void'(q.pop_front());
            end
         end
         if (q.size() > 0 && (!guard || on)) begin
            for (i = 0; i < 256; i++) mem[{q[0][26:16], 8'(i)}] = 8'hff;
            foreach (q[j]) mem[q[j][26:8]] = q[j][7:0];
         end
         q.delete();
      end
      if (rd && !prd && busy > 0) tog = !tog;
      prd = rd;
      pw  = pins.we_n;
      if (!rd) dq_in <= ~dq_in;
      else if (busy > 0) dq_in <= {~ld[7], tog, ld[5:0]};
      else dq_in <= mem.exists(pins.addr) ? mem[pins.addr] : 8'hff;
   end
endmodule

// *** sfpc_host_sva.sv ***
`timescale 1ns/10ps
// ============================================================
// Pin protocol checks
// ============================================================
module sfpc_host_sva #(
   parameter logic [20:0] LOAD_WINDOW_CYC = 21'h000c8
) (
   input wire logic                 clk,
   input wire logic                 rst_n,
   input wire logic                 cmd_valid,
   input wire logic                 cmd_ready,
   input wire sfpc_pkg::sfpc_cmd_t  cmd,
   input wire logic                 rsp_valid,
   input wire sfpc_pkg::sfpc_pins_t pins
);
   logic [20:0] gap;
   logic        pend;
   // Saturating, so a long idle spell never wraps into a false short gap.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         gap  <= 21'h00000;
         pend <= 1'b0;
      end else begin
         gap  <= !pins.we_n ? 21'h00000 : gap + 21'((gap != 21'h1fffff));
         pend <= !pins.we_n ? 1'b1 : (!pins.oe_n ? 1'b0 : pend);
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   rd_resp_delay_a: assert property (cmd_valid && cmd_ready && cmd.op == sfpc_pkg::OP_READ
      |-> ##13 rsp_valid) else $error("read answer late or early");
   rd_strobe_set_a: assert property (cmd_valid && cmd_ready && cmd.op == sfpc_pkg::OP_READ
      |=> !pins.ce_n && !pins.oe_n && pins.addr == $past(cmd.addr)) else $error("read strobes");
   bus_float_rd_a: assert property (!pins.oe_n |-> !pins.dq_oe && pins.we_n)
      else $error("host drives data during read");
   load_enables_a: assert property (!pins.we_n |-> !pins.ce_n && pins.oe_n && pins.dq_oe)
      else $error("load strobe without enables");
   we_pulse_width_a: assert property ($fell(pins.we_n) |-> (!pins.we_n)[*3] ##1 pins.we_n)
      else $error("write strobe width");
   addr_setup_a: assert property ($fell(pins.we_n) |-> $stable(pins.addr) && $past(pins.dq_oe))
      else $error("address not set up before strobe");
   data_hold_a: assert property ($rose(pins.we_n)
      |-> (pins.dq_oe && !pins.ce_n && $stable(pins.dq_out))[*3]) else $error("data hold");
   load_window_a: assert property ($fell(pins.we_n) && pend |-> gap < LOAD_WINDOW_CYC)
      else $error("byte load gap too long");
   poll_wait_a: assert property ($fell(pins.oe_n) && pend |-> gap > LOAD_WINDOW_CYC)
      else $error("polling before load window closed");
   rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid && cmd_ready)
      else $error("answer pulse");
endmodule
bind sfpc_host sfpc_host_sva #(.LOAD_WINDOW_CYC(LOAD_WINDOW_CYC)) chk (.clk(clk), .rst_n(rst_n),
   .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid), .pins(pins));

// *** tb.sv ***
`timescale 1ns/10ps
// ============================================================
// Testbench
// ============================================================
module tb;
   localparam logic [20:0] LW = 21'h000c8;
   localparam logic [20:0] PC = 21'h007d0;
   logic                 clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, wr_valid = 1'b0;
   logic                 cmd_ready, wr_ready, rsp_valid, guard_active;
   sfpc_pkg::sfpc_cmd_t  cmd = '0;
   sfpc_pkg::sfpc_load_t wr_load = '0;
   sfpc_pkg::sfpc_rsp_t  rsp;
   sfpc_pkg::sfpc_pins_t pins;
   logic [7:0]           dq_in, o0, d, sh [int];
   logic [19:0]          e, exp_q [$];
   logic [10:0]          sec;
   integer               seed = 32;
   int                   fails = 0, cmp_count = 0, cyc = 0, k;
   sfpc_host #(.LOAD_WINDOW_CYC(LW), .PROG_CYCLE_CYC(PC)) uut (.clk(clk), .rst_n(rst_n),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_load(wr_load), .rsp_valid(rsp_valid), .rsp(rsp),
      .guard_active(guard_active), .pins(pins), .dq_in(dq_in));
   sfpc_flash_model #(.LW(int'(LW))) dev (.clk(clk), .pins(pins), .dq_in(dq_in));
   initial forever #5 clk = ~clk;
   task automatic chk(input logic [9:0] got, input logic [9:0] ex);
      cmp_count++;
      if (got !== ex) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, ex);
      end
   endtask
   task automatic final_report;
      $display("compares=%0d mismatches=%0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // The ceiling is several times the expected run, so only a hang reaches it.
   always @(posedge clk) begin
      if (++cyc == 20000) begin
         fails++;
         final_report;
      end
   end
   always @(posedge clk) begin
      if (rsp_valid === 1'b1) begin
         e = exp_q.pop_front();
         chk(rsp & e[19:10], e[9:0]);
      end
   end
   task automatic op(input sfpc_pkg::sfpc_op_t o, input logic [18:0] a, input logic [8:0] n,
                     input logic [9:0] m, input logic [9:0] x);
      int j;
      exp_q.push_back({m, x & m});
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd = '{o, a, n};
      for (j = 0; j < 9000 && cmd_ready !== 1'b1; j++) @(negedge clk);
      @(negedge clk);
      cmd_valid = 1'b0;
      for (j = 0; j < 9000 && rsp_valid !== 1'b1; j++) @(negedge clk);
      @(negedge clk);
   endtask
   task automatic push(input logic [7:0] of, input logic [7:0] dt);
      @(negedge clk);
      while (wr_ready !== 1'b1) @(negedge clk);
      wr_valid = 1'b1;
      wr_load = '{of, dt};
   endtask
   task automatic rd(input logic [18:0] a);
      op(sfpc_pkg::OP_READ, a, 9'h000, 10'h3ff, {sh.exists(a) ? sh[a] : 8'hff, 2'b00});
   endtask
   // Offsets step by an odd stride, so bytes are distinct and out of order.
   task automatic prog(input logic [10:0] s, input int n, input logic [9:0] m,
                       input logic [1:0] f);
      int j;
      o0 = 8'($random(seed));
      for (j = 0; j < 256; j++) sh[{s, 8'(j)}] = 8'hff;
      for (j = 0; j < n; j++) begin
         d = 8'($random(seed));
         sh[{s, o0 + 8'(j * 37)}] = d;
         push(o0 + 8'(j * 37), d);
      end
      @(negedge clk);
      wr_valid = 1'b0;
      if (n == 16) chk({9'h000, wr_ready}, 10'h000);
      op(sfpc_pkg::OP_PROGRAM, {s, 8'h00}, 9'(n + int'(f[1])), m, {d, f});
   endtask
   initial begin
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      chk({3'h0, pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe, guard_active, cmd_ready,
           wr_ready}, 10'h073);
      sec = 11'($random(seed)) | 11'h400;
      rd({sec, 8'h5a});
      prog(sec, 3, 10'h3ff, 2'b00);
      for (k = 0; k < 4; k++) rd({sec, o0 + 8'(k * 37)});
      prog(sec + 11'h001, 16, 10'h3ff, 2'b00);
      rd({sec + 11'h001, o0 + 8'h25});
      op(sfpc_pkg::OP_GUARD_ON, 19'h00000, 9'h000, 10'h3ff,
         {sfpc_pkg::GUARD_ON_DATA[2], 2'b00});
      chk({9'h000, guard_active}, 10'h001);
      prog(sec, 2, 10'h3ff, 2'b00);
      rd({sec, o0 + 8'h25});
      @(negedge clk);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      chk({9'h000, guard_active}, 10'h001 ^ 10'h001);
      d = sh[{sec, o0}];
      push(o0, d ^ 8'h01);
      @(negedge clk);
      wr_valid = 1'b0;
      op(sfpc_pkg::OP_PROGRAM, {sec, 8'h00}, 9'h001, 10'h3ff, {d, 2'b00});
      rd({sec, o0});
      op(sfpc_pkg::OP_GUARD_OFF, 19'h00000, 9'h000, 10'h3ff,
         {sfpc_pkg::GUARD_OFF_DATA[2], 2'b00});
      prog(sec + 11'h002, 1, 10'h3ff, 2'b10);
      rd({sec + 11'h002, o0});
      dev.prog_t = 3000;
      prog(sec + 11'h003, 2, 10'h003, 2'b01);
      dev.prog_t = 60;
      repeat (1500) @(negedge clk);
      rd({sec + 11'h003, o0});
      final_report;
   end
endmodule
